// ===== rtl/pfbe_pkg.sv
`default_nettype none

// ---------------------------------------------------------------------------
// Shared constants and types of the program flash block erase sequencer
// ---------------------------------------------------------------------------
package pfbe_pkg;

   // ------------------------------------------------------------------------
   // Register port widths and offsets
   // ------------------------------------------------------------------------
   localparam int          ADDR_W        = 8;          // Register address width
   localparam int          DATA_W        = 8;          // Register data width
   localparam logic [7:0]  OFF_CONTROL   = 8'h00;      // nvm_control_reg
   localparam logic [7:0]  OFF_UNLOCK    = 8'h01;      // nvm_unlock_reg
   localparam logic [7:0]  OFF_TP_LOW    = 8'h02;      // table_pointer bits 7:0
   localparam logic [7:0]  OFF_TP_HIGH   = 8'h03;      // table_pointer bits 15:8
   localparam logic [7:0]  OFF_TP_UPPER  = 8'h04;      // table_pointer bits 21:16
   localparam logic [7:0]  OFF_FLASH_RD  = 8'h05;      // Flash byte at table_pointer

   // ------------------------------------------------------------------------
   // Control register field positions
   // ------------------------------------------------------------------------
   localparam int          BIT_PMSEL     = 7;          // program_memory_select
   localparam int          BIT_CFGSEL    = 6;          // config_space_select
   localparam int          BIT_ERASE     = 4;          // Erase select
   localparam int          BIT_NVM_WRITE_ENABLE      = 2;          // nvm_write_enable
   localparam int          BIT_START     = 1;          // Start / busy bit

   // ------------------------------------------------------------------------
   // Unlock key values
   // ------------------------------------------------------------------------
   localparam logic [7:0]  UNLOCK_KEY1   = 8'h55;      // First key write
   localparam logic [7:0]  UNLOCK_KEY2   = 8'hAA;      // Second key write

   // ------------------------------------------------------------------------
   // Flash geometry
   // ------------------------------------------------------------------------
   localparam int          TP_W          = 22;         // table_pointer width
   localparam int          MEM_AW        = 15;         // 32 KB byte address width
   localparam int          BLK_LSB       = 6;          // 64-byte block offset bits
   localparam int          MEM_BYTES     = 32768;      // Array size in bytes
   localparam logic [5:0]  BLK_LAST      = 6'h3F;      // Last byte index in a block
   localparam logic [7:0]  ERASED_BYTE   = 8'hFF;      // Value of an erased cell

   // ------------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------------
   localparam int          CLK_KHZ       = 20000;      // clk_sys rate, 20 MHz
   localparam int          ERASE_TIME_US = 2000;       // Erase time, 2 ms
   localparam int          ERASE_CYC     = ERASE_TIME_US * CLK_KHZ / 1000;
   localparam int          PWRT_CYC      = 1024;       // Power-up timer length
   localparam int          CNT_W         = 20;         // Timer counter width

   // ------------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------------
   typedef struct packed {
      logic pmsel;                                     // program_memory_select
      logic cfgsel;                                    // config_space_select
      logic erase;                                     // Erase select
      logic nvm_write_enable;                                      // nvm_write_enable
      logic start;                                     // Start / busy
   } pfbe_ctrl_t;

   typedef enum logic [1:0] {
      UNL_IDLE,                                        // No key seen
      UNL_KEY1,                                        // First key seen
      UNL_ARMED                                        // Both keys seen
   } pfbe_unlock_t;

   typedef enum logic [1:0] {
      SEQ_IDLE,                                        // Waiting for start
      SEQ_CLEAR,                                       // Writing ones into the block
      SEQ_TIMER                                        // Programming timer runs
   } pfbe_seq_t;

endpackage : pfbe_pkg

`default_nettype wire

// ===== rtl/pfbe_program_flash_block_erase.sv
`default_nettype none

// Notes on behaviour
// - Each erase clears one aligned 64-byte block
// - No single-word erase exists at all
// - Never erase more than one block
// - Block chosen by upper pointer bits only
// - No erase while write enable clear
// - Erase select makes start a block erase
// - Start accepted only after 55h, AAh
// - Start after unlock begins block erase
// - Core halted for whole erase time
// - Internal timer ends erase, core resumes
// - Start bit stays set until completion
// - Write enable kept after erase, writes ignored while busy
module pfbe_program_flash_block_erase #(
   parameter int ERASE_CYCLES = pfbe_pkg::ERASE_CYC,  // Erase time in clk_sys cycles
   parameter int PWRT_CYCLES  = pfbe_pkg::PWRT_CYC    // Power-up timer in cycles
) (
   input  wire logic                       clk_sys,   // System clock, 20 MHz
   input  wire logic                       rst,       // Synchronous reset, active high
   input  wire logic [pfbe_pkg::ADDR_W-1:0] reg_addr,  // Register address
   input  wire logic [pfbe_pkg::DATA_W-1:0] reg_wdata, // Register write data
   input  wire logic                       reg_wr,    // Write strobe
   input  wire logic                       reg_rd,    // Read strobe
   output logic      [pfbe_pkg::DATA_W-1:0] reg_rdata, // Read data, one cycle later
   output logic                            core_stall // Halts instruction execution
);

   timeunit 1ns;
   timeprecision 1ns;

   // ------------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------------
   pfbe_pkg::pfbe_ctrl_t                ctrl_reg;        // Control bits
   pfbe_pkg::pfbe_ctrl_t                ctrl_next;
   pfbe_pkg::pfbe_unlock_t              unlock_reg;      // Unlock key tracker
   pfbe_pkg::pfbe_unlock_t              unlock_next;
   pfbe_pkg::pfbe_seq_t                 seq_reg;         // Erase sequencer state
   pfbe_pkg::pfbe_seq_t                 seq_next;
   logic [pfbe_pkg::TP_W-1:0]           tp_reg;          // table_pointer
   logic [pfbe_pkg::TP_W-1:0]           tp_next;
   logic [pfbe_pkg::TP_W-1:pfbe_pkg::BLK_LSB] blk_reg;   // Latched block number
   logic [pfbe_pkg::TP_W-1:pfbe_pkg::BLK_LSB] blk_next;
   logic [5:0]                          idx_reg;         // Byte index inside block
   logic [5:0]                          idx_next;
   logic [pfbe_pkg::CNT_W-1:0]          tmr_reg;         // Programming timer
   logic [pfbe_pkg::CNT_W-1:0]          tmr_next;
   logic [pfbe_pkg::CNT_W-1:0]          pwrt_reg;        // Power-up timer
   logic [pfbe_pkg::CNT_W-1:0]          pwrt_next;
   logic [pfbe_pkg::DATA_W-1:0]         rdata_reg;       // Read data register
   logic [pfbe_pkg::DATA_W-1:0]         rdata_next;
   logic                                stall_reg;       // Core halt register
   logic                                stall_next;

   // ------------------------------------------------------------------------
   // Flash array and its write port
   // ------------------------------------------------------------------------
   logic [7:0]                          flash_mem [0:pfbe_pkg::MEM_BYTES-1];
   logic                                mem_we;          // Write one erased byte
   logic [pfbe_pkg::MEM_AW-1:0]         mem_waddr;       // Byte being erased

   // ------------------------------------------------------------------------
   // Decoded helpers
   // ------------------------------------------------------------------------
   logic                                pwrt_done;       // Power-up timer expired
   logic                                blk_in_array;    // Pointer hits the array
   logic                                erase_ok;        // All erase conditions met
   logic [pfbe_pkg::DATA_W-1:0]         ctrl_rd;         // Control readback

   // Power-up timer has reached its end
   assign pwrt_done    = (pwrt_reg == pfbe_pkg::CNT_W'(PWRT_CYCLES));

   // Pointer bits above the 32 KB array must be zero to address a block
   assign blk_in_array = (tp_reg[pfbe_pkg::TP_W-1:pfbe_pkg::MEM_AW] == '0);

   // Erase is legal only for program flash, write enabled, after power-up
   assign erase_ok = ctrl_reg.nvm_write_enable && pwrt_done
                  && ctrl_reg.pmsel && !ctrl_reg.cfgsel
                  && blk_in_array;

   // Control register as software reads it; other bits read as zero
   always_comb begin
      ctrl_rd                       = '0;
      ctrl_rd[pfbe_pkg::BIT_PMSEL]  = ctrl_reg.pmsel;
      ctrl_rd[pfbe_pkg::BIT_CFGSEL] = ctrl_reg.cfgsel;
      ctrl_rd[pfbe_pkg::BIT_ERASE]  = ctrl_reg.erase;
      ctrl_rd[pfbe_pkg::BIT_NVM_WRITE_ENABLE]   = ctrl_reg.nvm_write_enable;
      ctrl_rd[pfbe_pkg::BIT_START]  = ctrl_reg.start;
   end

   // ------------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------------
   // Register writes, unlock tracking, erase sequencing and timers
   always_comb begin
      ctrl_next   = ctrl_reg;
      unlock_next = unlock_reg;
      seq_next    = seq_reg;
      tp_next     = tp_reg;
      blk_next    = blk_reg;
      idx_next    = idx_reg;
      tmr_next    = tmr_reg;
      pwrt_next   = pwrt_reg;
      mem_we      = 1'b0;
      mem_waddr   = {blk_reg[pfbe_pkg::MEM_AW-1:pfbe_pkg::BLK_LSB], idx_reg};

      // Power-up timer counts once after reset, then holds
      if (!pwrt_done) begin
         pwrt_next = pwrt_reg + 1'b1;
      end

      unique case (seq_reg)
         // Idle: software owns the registers
         pfbe_pkg::SEQ_IDLE: begin
            if (reg_wr) begin
               // Any write breaks an unfinished unlock unless it continues it
               unlock_next = pfbe_pkg::UNL_IDLE;
               unique case (reg_addr)
                  pfbe_pkg::OFF_CONTROL: begin
                     ctrl_next.pmsel  = reg_wdata[pfbe_pkg::BIT_PMSEL];
                     ctrl_next.cfgsel = reg_wdata[pfbe_pkg::BIT_CFGSEL];
                     ctrl_next.erase  = reg_wdata[pfbe_pkg::BIT_ERASE];
                     // Write enable cannot be set during power-up time
                     ctrl_next.nvm_write_enable   = reg_wdata[pfbe_pkg::BIT_NVM_WRITE_ENABLE] && pwrt_done;
                     // Start only after the unlock pair and with all conditions
                     if (reg_wdata[pfbe_pkg::BIT_START]
                         && unlock_reg == pfbe_pkg::UNL_ARMED
                         && ctrl_reg.erase
                         && erase_ok) begin
                        ctrl_next.start = 1'b1;
                        // Only bits above the block offset select it
                        blk_next = tp_reg[pfbe_pkg::TP_W-1:pfbe_pkg::BLK_LSB];
                        idx_next = '0;
                        tmr_next = '0;
                        seq_next = pfbe_pkg::SEQ_CLEAR;
                     end
                  end
                  pfbe_pkg::OFF_UNLOCK: begin
                     // Key pair 55h then AAh arms the start bit
                     if (reg_wdata == pfbe_pkg::UNLOCK_KEY1) begin
                        unlock_next = pfbe_pkg::UNL_KEY1;
                     end else if (reg_wdata == pfbe_pkg::UNLOCK_KEY2
                                  && unlock_reg == pfbe_pkg::UNL_KEY1) begin
                        unlock_next = pfbe_pkg::UNL_ARMED;
                     end
                  end
                  pfbe_pkg::OFF_TP_LOW: begin
                     tp_next[7:0] = reg_wdata;
                  end
                  pfbe_pkg::OFF_TP_HIGH: begin
                     tp_next[15:8] = reg_wdata;
                  end
                  pfbe_pkg::OFF_TP_UPPER: begin
                     tp_next[pfbe_pkg::TP_W-1:16] = reg_wdata[pfbe_pkg::TP_W-17:0];
                  end
                  default: begin
                     // Unmapped or read-only offsets ignore writes
                  end
               endcase
            end
         end

         // Clear: one byte of the latched block per cycle, 64 in all
         pfbe_pkg::SEQ_CLEAR: begin
            mem_we   = 1'b1;
            tmr_next = tmr_reg + 1'b1;
            idx_next = idx_reg + 1'b1;
            // Stop at the block's last byte so no neighbour is touched
            if (idx_reg == pfbe_pkg::BLK_LAST) begin
               seq_next = pfbe_pkg::SEQ_TIMER;
            end
         end

         // Timer: hold the core for the rest of the erase time
         pfbe_pkg::SEQ_TIMER: begin
            tmr_next = tmr_reg + 1'b1;
            if (tmr_reg >= pfbe_pkg::CNT_W'(ERASE_CYCLES - 1)) begin
               seq_next        = pfbe_pkg::SEQ_IDLE;
               ctrl_next.start = 1'b0;
               tmr_next        = '0;
            end
         end

         default: begin
            seq_next = pfbe_pkg::SEQ_IDLE;
         end
      endcase

      // Writes during an erase never reach the registers: the core is halted
      stall_next = (seq_next != pfbe_pkg::SEQ_IDLE);
   end

   // Read data path: answer stands only in the cycle after the strobe
   always_comb begin
      rdata_next = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            pfbe_pkg::OFF_CONTROL:  rdata_next = ctrl_rd;
            pfbe_pkg::OFF_TP_LOW:   rdata_next = tp_reg[7:0];
            pfbe_pkg::OFF_TP_HIGH:  rdata_next = tp_reg[15:8];
            pfbe_pkg::OFF_TP_UPPER: rdata_next = {2'h0, tp_reg[pfbe_pkg::TP_W-1:16]};
            pfbe_pkg::OFF_FLASH_RD: rdata_next = flash_mem[tp_reg[pfbe_pkg::MEM_AW-1:0]];
            default:                rdata_next = '0;
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------------
   // State update; write enable is clear after reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_reg   <= '0;
         unlock_reg <= pfbe_pkg::UNL_IDLE;
         seq_reg    <= pfbe_pkg::SEQ_IDLE;
         tp_reg     <= '0;
         blk_reg    <= '0;
         idx_reg    <= '0;
         tmr_reg    <= '0;
         pwrt_reg   <= '0;
         rdata_reg  <= '0;
         stall_reg  <= 1'b0;
      end else begin
         ctrl_reg   <= ctrl_next;
         unlock_reg <= unlock_next;
         seq_reg    <= seq_next;
         tp_reg     <= tp_next;
         blk_reg    <= blk_next;
         idx_reg    <= idx_next;
         tmr_reg    <= tmr_next;
         pwrt_reg   <= pwrt_next;
         rdata_reg  <= rdata_next;
         stall_reg  <= stall_next;
      end
   end

   // Flash cells take the erased value one byte at a time; a plain always
   // lets a bench preload the array, which has no write path of its own
   always @(posedge clk_sys) begin
      if (mem_we) begin
         flash_mem[mem_waddr] <= pfbe_pkg::ERASED_BYTE;
      end
   end

   // ------------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------------
   assign reg_rdata  = rdata_reg;
   assign core_stall = stall_reg;

endmodule : pfbe_program_flash_block_erase

`default_nettype wire

// ===== verif/pfbe_core_model.sv
`default_nettype none
// ---------------------------------------------------------------------------
// Processor core model: software side of the register port
// ---------------------------------------------------------------------------
module pfbe_core_model (
   input  wire logic                        clk_sys,   // System clock
   output var  logic [pfbe_pkg::ADDR_W-1:0] reg_addr,  // Register address
   output var  logic [pfbe_pkg::DATA_W-1:0] reg_wdata, // Write data
   output var  logic                        reg_wr,    // Write strobe
   output var  logic                        reg_rd,    // Read strobe
   input  wire logic [pfbe_pkg::DATA_W-1:0] reg_rdata  // Read data
);
   timeunit 1ns;
   timeprecision 1ns;
   // Bus quiet at time zero
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end
   // Write; strobe stays up until the next command or idle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      reg_rd    <= 1'b0;
      @(posedge clk_sys);
   endtask : wr
   // Idle cycle; unused lines toggle so stale values never match
   task automatic idle();
      reg_addr  <= ~reg_addr;
      reg_wdata <= ~reg_wdata;
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      @(posedge clk_sys);
   endtask : idle
   // Read; data taken in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr  <= a;
      reg_wdata <= ~reg_wdata;
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      @(posedge clk_sys);
      reg_rd    <= 1'b0;
      reg_addr  <= ~a;
      @(negedge clk_sys);
      d = reg_rdata;
      @(posedge clk_sys);
   endtask : rd
   // Erase sequence; interrupts are assumed off around the keys
   task automatic erase_seq(input logic [21:0] ptr, input logic [7:0] cfg,
                            input logic [7:0] k1, input logic [7:0] k2);
      wr(pfbe_pkg::OFF_TP_LOW, ptr[7:0]);
      wr(pfbe_pkg::OFF_TP_HIGH, ptr[15:8]);
      wr(pfbe_pkg::OFF_TP_UPPER, {2'b00, ptr[21:16]});
      wr(pfbe_pkg::OFF_CONTROL, cfg);
      wr(pfbe_pkg::OFF_UNLOCK, k1);
      wr(pfbe_pkg::OFF_UNLOCK, k2);
      wr(pfbe_pkg::OFF_CONTROL, cfg | 8'h02);
      idle();
   endtask : erase_seq
endmodule : pfbe_core_model
`default_nettype wire

// ===== verif/pfbe_program_flash_block_erase_assertions.sv
`default_nettype none
// ---------------------------------------------------------------------------
// Port checker of the block erase sequencer
// ---------------------------------------------------------------------------
module pfbe_checker #(
   parameter int ERASE_CYCLES = 100,                   // Erase time in cycles
   parameter int PWRT_CYCLES  = 8                      // Power-up timer in cycles
) (
   input  wire logic                        clk_sys,   // System clock
   input  wire logic                        rst,       // Synchronous reset
   input  wire logic [pfbe_pkg::ADDR_W-1:0] reg_addr,  // Register address
   input  wire logic [pfbe_pkg::DATA_W-1:0] reg_wdata, // Write data
   input  wire logic                        reg_wr,    // Write strobe
   input  wire logic                        reg_rd,    // Read strobe
   input  wire logic [pfbe_pkg::DATA_W-1:0] reg_rdata, // Read data
   input  wire logic                        core_stall // Core halt
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [19:0] stall_cnt_reg;                         // High cycles of core_stall
   logic [19:0] stall_cnt_next;
   logic [19:0] up_cnt_reg;                            // Cycles since reset, saturating
   logic [19:0] up_cnt_next;
   // Helper counters: next values
   always_comb begin
      stall_cnt_next = core_stall ? stall_cnt_reg + 20'h0_0001 : 20'h0_0000;
      up_cnt_next    = (up_cnt_reg < PWRT_CYCLES) ? up_cnt_reg + 20'h0_0001 : up_cnt_reg;
   end
   // Helper counters: registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stall_cnt_reg <= 20'h0_0000;
         up_cnt_reg    <= 20'h0_0000;
      end else begin
         stall_cnt_reg <= stall_cnt_next;
         up_cnt_reg    <= up_cnt_next;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   AST_RD_IDLE: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
      else $error("read data outside a read cycle");
   AST_START_WRITE: assert property ($rose(core_stall) |->
      $past(reg_wr && reg_addr == pfbe_pkg::OFF_CONTROL && reg_wdata[pfbe_pkg::BIT_START]))
      else $error("stall without a start write");
   AST_KEY_PAIR: assert property ($rose(core_stall) |->
      $past(reg_wr && reg_addr == pfbe_pkg::OFF_UNLOCK && reg_wdata == pfbe_pkg::UNLOCK_KEY2, 2)
      && $past(reg_wr && reg_addr == pfbe_pkg::OFF_UNLOCK && reg_wdata == pfbe_pkg::UNLOCK_KEY1, 3))
      else $error("stall without the key pair");
   AST_STALL_LEN: assert property ($fell(core_stall) |-> stall_cnt_reg == ERASE_CYCLES)
      else $error("stall length wrong");
   AST_STALL_MAX: assert property (stall_cnt_reg <= ERASE_CYCLES)
      else $error("stall outlasts the erase time");
   AST_STALL_HOLD: assert property ($rose(core_stall) |=> core_stall [*8])
      else $error("stall dropped early");
   AST_START_BUSY: assert property (reg_rd && reg_addr == pfbe_pkg::OFF_CONTROL |=>
      reg_rdata[pfbe_pkg::BIT_START] == $past(core_stall))
      else $error("start bit differs from busy state");
   AST_NVM_WRITE_ENABLE_PWRT: assert property (reg_rd && reg_addr == pfbe_pkg::OFF_CONTROL
      && up_cnt_reg < PWRT_CYCLES - 1 |=> !reg_rdata[pfbe_pkg::BIT_NVM_WRITE_ENABLE])
      else $error("write enable set during power-up time");
   AST_PWRT_STALL: assert property (core_stall |-> up_cnt_reg == PWRT_CYCLES)
      else $error("erase during power-up time");
endmodule : pfbe_checker
bind pfbe_program_flash_block_erase pfbe_checker #(.ERASE_CYCLES(ERASE_CYCLES),
   .PWRT_CYCLES(PWRT_CYCLES)) pfbe_checker_inst (.clk_sys(clk_sys), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .core_stall(core_stall));
`default_nettype wire

// ===== verif/pfbe_program_flash_block_erase_tb_top.sv
`default_nettype none
// ---------------------------------------------------------------------------
// Self-checking bench of the block erase sequencer
// ---------------------------------------------------------------------------
module pfbe_program_flash_block_erase_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int         ERASE_N = 100;              // Shortened erase time
   localparam int         PWRT_N  = 8;                // Shortened power-up time
   // Refusal table and one good case: control, keys, pointer, expected start
   localparam logic [7:0]  CFG_T [8] = '{8'h90, 8'h84, 8'h14, 8'hD4, 8'h94, 8'h94, 8'h94, 8'h94};
   localparam logic [7:0]  K1_T  [8] = '{8'h55, 8'h55, 8'h55, 8'h55, 8'hAA, 8'h00, 8'h55, 8'h55};
   localparam logic [7:0]  K2_T  [8] = '{8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'h55, 8'h00, 8'hAA, 8'hAA};
   localparam logic [21:0] PTR_T [8] = '{22'h00_0100, 22'h00_0140, 22'h00_0180, 22'h00_01C0,
                                         22'h00_0200, 22'h00_0240, 22'h00_8000, 22'h00_001F};
   logic       clk_sys;                               // System clock
   logic       rst;                                   // Reset
   logic [7:0] reg_addr;                              // Register address
   logic [7:0] reg_wdata;                             // Write data
   logic       reg_wr;                                // Write strobe
   logic       reg_rd;                                // Read strobe
   logic [7:0] reg_rdata;                             // Read data
   logic       core_stall;                            // Core halt
   logic [7:0] exp_mem [pfbe_pkg::MEM_BYTES];         // Expected flash content
   logic [7:0] d;                                     // Scratch read value
   int         failures;                              // Mismatches
   int         check_count;                           // Comparisons
   pfbe_program_flash_block_erase #(.ERASE_CYCLES(ERASE_N), .PWRT_CYCLES(PWRT_N))
      pfbe_program_flash_block_erase_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .core_stall(core_stall));
   pfbe_core_model pfbe_core_model_inst (.clk_sys(clk_sys), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   // Clock, 50 ns period
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // Compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] expct);
      check_count++;
      if (seen !== expct) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expct);
      end
   endtask : chk
   // Verdict and end of run
   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim
   // Preload pattern of the flash array
   function automatic logic [7:0] pat(input logic [14:0] a);
      return a[7:0] ^ a[14:7] ^ 8'h3C;
   endfunction : pat
   // Read one flash byte through the pointer and compare
   task automatic chk_byte(input logic [14:0] a);
      logic [7:0] v;
      pfbe_core_model_inst.wr(pfbe_pkg::OFF_TP_LOW, a[7:0]);
      pfbe_core_model_inst.wr(pfbe_pkg::OFF_TP_HIGH, {1'b0, a[14:8]});
      pfbe_core_model_inst.wr(pfbe_pkg::OFF_TP_UPPER, 8'h00);
      pfbe_core_model_inst.rd(pfbe_pkg::OFF_FLASH_RD, v);
      chk(v, exp_mem[a]);
   endtask : chk_byte
   // One erase attempt, then the block and its neighbours read back
   task automatic run(input logic [21:0] ptr, input logic [7:0] cfg, input logic [7:0] k1,
                      input logic [7:0] k2, input logic go);
      int         n;
      int         base;
      logic [7:0] v;
      base = int'(ptr[14:6]) * 64;
      pfbe_core_model_inst.erase_seq(ptr, cfg, k1, k2);
      @(negedge clk_sys);
      chk({7'h00, core_stall}, {7'h00, go});
      @(posedge clk_sys);
      if (go) begin
         pfbe_core_model_inst.wr(pfbe_pkg::OFF_CONTROL, 8'h00);
         pfbe_core_model_inst.rd(pfbe_pkg::OFF_CONTROL, v);
         chk(v & 8'h02, 8'h02);
         // Count stall at falling edges, from the sixth cycle after start
         n = 0;
         @(negedge clk_sys);
         while (core_stall === 1'b1 && n < 1000) begin
            @(negedge clk_sys);
            n++;
         end
         @(posedge clk_sys);
         chk(8'(n), 8'(ERASE_N - 5));
         for (int i = 0; i < 64; i++) begin
            exp_mem[base + i] = pfbe_pkg::ERASED_BYTE;
         end
      end
      pfbe_core_model_inst.rd(pfbe_pkg::OFF_CONTROL, v);
      chk(v & 8'h02, 8'h00);
      for (int i = -1; i <= 64; i++) begin
         if (base + i >= 0 && base + i < pfbe_pkg::MEM_BYTES) begin
            chk_byte(15'(base + i));
         end
      end
   endtask : run
   // Main sequence
   initial begin
      rst         = 1'b1;
      failures    = 0;
      check_count = 0;
      void'($urandom(32'h1b3f_0e05));
      for (int i = 0; i < pfbe_pkg::MEM_BYTES; i++) begin
         exp_mem[i] = pat(15'(i));
         pfbe_program_flash_block_erase_inst.flash_mem[i] = pat(15'(i));
      end
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      pfbe_core_model_inst.wr(pfbe_pkg::OFF_CONTROL, 8'h84);
      pfbe_core_model_inst.rd(pfbe_pkg::OFF_CONTROL, d);
      chk(d & 8'h04, 8'h00);
      pfbe_core_model_inst.rd(pfbe_pkg::OFF_UNLOCK, d);
      chk(d, 8'h00);
      pfbe_core_model_inst.rd(8'h77, d);
      chk(d, 8'h00);
      repeat (PWRT_N) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
         run(PTR_T[i], CFG_T[i], K1_T[i], K2_T[i], 1'(i == 7));
      end
      run({7'h00, 9'h1FF, 6'($urandom)}, 8'h94, 8'h55, 8'hAA, 1'b1);
      for (int i = 0; i < 3; i++) begin
         run({7'h00, 9'($urandom_range(0, 511)), 6'($urandom)}, 8'h94, 8'h55, 8'hAA, 1'b1);
      end
      end_sim();
   end
   // Watchdog against a hang
   initial begin
      repeat (40000) @(posedge clk_sys);
      failures++;
      end_sim();
   end
endmodule : pfbe_program_flash_block_erase_tb_top
`default_nettype wire
